// ===== hw/exec_pkg.sv
// Purpose: shared constants and types for the skip, branch and literal execution slice
// Assumes: 16-bit instruction words, 8-bit data, four clock phases per instruction cycle
// Notes:   opcodes are matched on the leading bits named by each constant
package exec_pkg;

  // widths
  localparam int DATA_W  = 8;
  localparam int WORD_W  = 16;
  localparam int BANK_W  = 4;
  localparam int FADDR_W = 12;
  localparam int PC_W    = 21;

  // phases inside one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // opcode fields, upper six bits of file-register forms
  localparam logic [5:0] OP6_DEC_SKIP_ZERO    = 6'h0B;
  localparam logic [5:0] OP6_INC_SKIP_ZERO    = 6'h0F;
  localparam logic [5:0] OP6_DEC_SKIP_NONZERO = 6'h13;
  localparam logic [5:0] OP6_INC_SKIP_NONZERO = 6'h12;
  localparam logic [5:0] OP6_INCREMENT        = 6'h0A;

  // literal and long forms
  localparam logic [7:0]  OP8_FAR_JUMP   = 8'hEF;
  localparam logic [7:0]  OP8_OR_LITERAL = 8'h09;
  localparam logic [15:0] OP16_DEC_ADJ   = 16'h0007;

  // first words of the other two-word instructions
  localparam logic [3:0] OP4_MOVE_FILE = 4'hC;
  localparam logic [6:0] OP7_CALL      = 7'h76;
  localparam logic [7:0] OP8_LOAD_PTR  = 8'hEE;

  // operand bit positions and meanings
  localparam int         BIT_DEST     = 9;
  localparam int         BIT_BANK     = 8;
  localparam int         BIT_ACC_HALF = 7;
  localparam logic       DEST_ACCUM   = 1'b0;
  localparam logic       BANK_FIXED   = 1'b0;
  localparam logic [3:0] ACC_LO_BANK  = 4'h0;
  localparam logic [3:0] ACC_HI_BANK  = 4'hF;

  // far jump literal split
  localparam int JUMP_LO_W = 8;
  localparam int JUMP_HI_W = 12;

  // decimal adjust
  localparam logic [3:0] DADJ_LIMIT = 4'h9;
  localparam logic [3:0] DADJ_STEP  = 4'h6;

  // idle cycles after a taken skip
  localparam logic [1:0] SKIP_IDLE_ONE = 2'h1;
  localparam logic [1:0] SKIP_IDLE_TWO = 2'h2;

  // reset values
  localparam logic [7:0] ACCUM_RESET = 8'h00;

  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_INC,
    ALU_DEC,
    ALU_OR,
    ALU_DADJ
  } alu_op_t;

  typedef enum logic [1:0] {
    ST_EXEC,
    ST_SKIP_IDLE,
    ST_JUMP_IDLE
  } exec_state_t;

endpackage : exec_pkg

// ===== hw/exec_alu.sv
// Purpose: combinational data path for increment, decrement, literal OR and decimal adjust
// Assumes: caller registers the outputs in the compute phase
// Notes:   negative and zero come from every op, carry from increment and decimal adjust, the others from increment only; the caller picks which to commit
`timescale 1ns/10ps
module exec_alu #(
  parameter int W = 8
) (
  input  wire exec_pkg::alu_op_t op_in,
  input  wire logic [W-1:0]      opnd_in,
  input  wire logic [W-1:0]      accum_in,
  input  wire logic [W-1:0]      lit_in,
  input  wire logic              carry_in,
  input  wire logic              ncarry_in,
  output logic      [W-1:0]      res_out,
  output logic                   carry_out,
  output logic                   ncarry_out,
  output logic                   neg_out,
  output logic                   ovf_out,
  output logic                   zero_out
);

  // one op per cycle, chosen by the decoder
  always_comb begin
    logic [W:0] sum;
    logic [4:0] low;
    logic [W:0] adj;
    sum        = '0;
    low        = '0;
    adj        = '0;
    res_out    = opnd_in;
    carry_out  = carry_in;
    ncarry_out = ncarry_in;
    ovf_out    = 1'b0;
    unique case (op_in)
      exec_pkg::ALU_INC: begin
        sum        = {1'b0, opnd_in} + {{W{1'b0}}, 1'b1};
        res_out    = sum[W-1:0];
        carry_out  = sum[W];
        ncarry_out = (opnd_in[3:0] == 4'hF);
        ovf_out    = ~opnd_in[W-1] & sum[W-1];
      end
      exec_pkg::ALU_DEC: begin
        res_out = opnd_in - {{(W-1){1'b0}}, 1'b1};
      end
      exec_pkg::ALU_OR: begin
        res_out = accum_in | lit_in;
      end
      exec_pkg::ALU_DADJ: begin
        // low digit first, its carry ripples into the high digit
        low = {1'b0, accum_in[3:0]};
        if (accum_in[3:0] > exec_pkg::DADJ_LIMIT || ncarry_in) begin
          low = low + {1'b0, exec_pkg::DADJ_STEP};
        end
        adj = {1'b0, accum_in[W-1:4], 4'h0} + {{(W-4){1'b0}}, low};
        if (adj[W-1:4] > exec_pkg::DADJ_LIMIT || carry_in) begin
          adj = adj + {1'b0, exec_pkg::DADJ_STEP, 4'h0};
        end
        res_out   = adj[W-1:0];
        carry_out = adj[W] | carry_in;
      end
      default: begin
        res_out = opnd_in;
      end
    endcase
    neg_out  = res_out[W-1];
    zero_out = (res_out == '0);
  end

endmodule : exec_alu

// ===== hw/skip_branch_or_instr_exec.sv
// Purpose: execution of the skip, far jump, increment, literal OR and decimal adjust instructions
// Assumes: fetch holds the current word and the prefetched next word steady for a whole cycle
// Notes:   one instruction cycle is four clocks, phases Q1 to Q4 in turn from reset
//
// Summary of operation
// - a taken skip drops the fetched next word and runs one idle cycle instead.
// - a taken skip over a two-word instruction inserts two idle cycles, three in total.
// - decrement-skip-on-nonzero decrements and skips only when the result is not zero.
// - increment-skip-on-zero increments, stores at destination, skips when the result is zero.
// - increment-skip-on-nonzero increments, skips on nonzero result, leaves all flags alone.
// - destination bit 0 sends the result to the accumulator, 1 back to the file.
// - bank bit 0 uses the fixed quick-access bank, 1 uses the bank pointer.
// - far jump loads its 20-bit literal into program counter bits 20 to 1.
// - far jump takes two words, two cycles; counter written after the first cycle.
// - OR-literal ORs an eight-bit literal into the accumulator, updates negative and zero.
// - decimal adjust adds six per digit above nine or with its carry, sets carry.
`timescale 1ns/10ps
module skip_branch_or_instr_exec #(
  parameter int DATA_W = exec_pkg::DATA_W
) (
  input  wire logic                       MCLK_IN,
  input  wire logic                       RESETN_IN,
  input  wire logic [exec_pkg::WORD_W-1:0] INSTR_IN,
  input  wire logic [exec_pkg::WORD_W-1:0] NEXT_WORD_IN,
  input  wire logic [exec_pkg::BANK_W-1:0] BANK_PTR_IN,
  input  wire logic [DATA_W-1:0]          REG_RDATA_IN,
  output logic      [exec_pkg::FADDR_W-1:0] REG_ADDR_OUT,
  output logic                            REG_RD_EN_OUT,
  output logic                            REG_WR_EN_OUT,
  output logic      [DATA_W-1:0]          REG_WDATA_OUT,
  output logic      [exec_pkg::PC_W-1:0]  PC_TARGET_OUT,
  output logic                            PC_LOAD_OUT,
  output logic                            WORD_DONE_OUT,
  output logic                            DISCARD_OUT,
  output logic                            UNHANDLED_OUT,
  output logic      [1:0]                 PHASE_OUT,
  output logic      [DATA_W-1:0]          ACCUM_OUT,
  output logic                            CARRY_FLAG_OUT,
  output logic                            NIBBLE_CARRY_FLAG_OUT,
  output logic                            NEG_FLAG_OUT,
  output logic                            OVF_FLAG_OUT,
  output logic                            ZERO_FLAG_OUT
);

  // sequencing state
  logic [1:0]                     phase_q,    phase_d;
  exec_pkg::exec_state_t          state_q,    state_d;
  logic [1:0]                     idle_left_q, idle_left_d;

  // instruction and data path registers
  logic [exec_pkg::WORD_W-1:0]    instr_q,    instr_d;
  logic [exec_pkg::FADDR_W-1:0]   addr_q,     addr_d;
  logic [DATA_W-1:0]              opnd_q,     opnd_d;
  logic [DATA_W-1:0]              result_q,   result_d;
  logic [exec_pkg::PC_W-1:0]      target_q,   target_d;
  logic [DATA_W-1:0]              accum_q,    accum_d;

  // status flags and the values computed for them in Q3
  logic                           carry_q,    carry_d;
  logic                           ncarry_q,   ncarry_d;
  logic                           neg_q,      neg_d;
  logic                           ovf_q,      ovf_d;
  logic                           zero_q,     zero_d;
  logic                           p_carry_q,  p_carry_d;
  logic                           p_ncarry_q, p_ncarry_d;
  logic                           p_neg_q,    p_neg_d;
  logic                           p_ovf_q,    p_ovf_d;
  logic                           p_zero_q,   p_zero_d;

  // decode of the word held since Q1
  logic                           is_dsz, is_isz, is_dsnz, is_isnz, is_inc;
  logic                           is_jump, is_orlit, is_dadj;
  logic                           is_file, is_skip_op, to_file, executing;
  logic                           next_two_word, skip_taken;
  exec_pkg::alu_op_t              alu_op;
  logic [DATA_W-1:0]              alu_res;
  logic                           alu_c, alu_dc, alu_n, alu_ov, alu_z;
  logic [exec_pkg::BANK_W-1:0]    bank_sel;

  // opcode decode from the latched word
  always_comb begin
    is_dsz     = (instr_q[15:10] == exec_pkg::OP6_DEC_SKIP_ZERO);
    is_dsnz    = (instr_q[15:10] == exec_pkg::OP6_DEC_SKIP_NONZERO);
    is_isz     = (instr_q[15:10] == exec_pkg::OP6_INC_SKIP_ZERO);
    is_isnz    = (instr_q[15:10] == exec_pkg::OP6_INC_SKIP_NONZERO);
    is_inc     = (instr_q[15:10] == exec_pkg::OP6_INCREMENT);
    is_jump    = (instr_q[15:8] == exec_pkg::OP8_FAR_JUMP);
    is_orlit   = (instr_q[15:8] == exec_pkg::OP8_OR_LITERAL);
    is_dadj    = (instr_q == exec_pkg::OP16_DEC_ADJ);
    is_skip_op = is_dsz | is_dsnz | is_isz | is_isnz;
    is_file    = is_skip_op | is_inc;
    to_file    = (instr_q[exec_pkg::BIT_DEST] != exec_pkg::DEST_ACCUM);
    executing  = (state_q == exec_pkg::ST_EXEC);
    if (is_dsz || is_dsnz) begin
      alu_op = exec_pkg::ALU_DEC;
    end else if (is_isz || is_isnz || is_inc) begin
      alu_op = exec_pkg::ALU_INC;
    end else if (is_orlit) begin
      alu_op = exec_pkg::ALU_OR;
    end else if (is_dadj) begin
      alu_op = exec_pkg::ALU_DADJ;
    end else begin
      alu_op = exec_pkg::ALU_NONE;
    end
  end

  // bank choice for the incoming word and the shape of the prefetched word
  always_comb begin
    if (INSTR_IN[exec_pkg::BIT_BANK] == exec_pkg::BANK_FIXED) begin
      bank_sel = INSTR_IN[exec_pkg::BIT_ACC_HALF] ? exec_pkg::ACC_HI_BANK : exec_pkg::ACC_LO_BANK;
    end else begin
      bank_sel = BANK_PTR_IN;
    end
    next_two_word = (NEXT_WORD_IN[15:12] == exec_pkg::OP4_MOVE_FILE)
                  | (NEXT_WORD_IN[15:9]  == exec_pkg::OP7_CALL)
                  | (NEXT_WORD_IN[15:8]  == exec_pkg::OP8_LOAD_PTR)
                  | (NEXT_WORD_IN[15:8]  == exec_pkg::OP8_FAR_JUMP);
    skip_taken = ((is_dsz || is_isz) && (result_q == '0))
               | ((is_dsnz || is_isnz) && (result_q != '0));
  end

  exec_alu #(
    .W (DATA_W)
  ) u_alu (
    .op_in      (alu_op),
    .opnd_in    (opnd_q),
    .accum_in   (accum_q),
    .lit_in     (instr_q[7:0]),
    .carry_in   (carry_q),
    .ncarry_in  (ncarry_q),
    .res_out    (alu_res),
    .carry_out  (alu_c),
    .ncarry_out (alu_dc),
    .neg_out    (alu_n),
    .ovf_out    (alu_ov),
    .zero_out   (alu_z)
  );

  // next values of the sequencer, data path and flags
  always_comb begin
    phase_d     = phase_q + 2'h1;
    state_d     = state_q;
    idle_left_d = idle_left_q;
    instr_d     = instr_q;
    addr_d      = addr_q;
    opnd_d      = opnd_q;
    result_d    = result_q;
    target_d    = target_q;
    accum_d     = accum_q;
    carry_d     = carry_q;
    ncarry_d    = ncarry_q;
    neg_d       = neg_q;
    ovf_d       = ovf_q;
    zero_d      = zero_q;
    p_carry_d   = p_carry_q;
    p_ncarry_d  = p_ncarry_q;
    p_neg_d     = p_neg_q;
    p_ovf_d     = p_ovf_q;
    p_zero_d    = p_zero_q;
    unique case (phase_q)
      exec_pkg::PH_Q1: begin
        // decode: capture the word and its file address
        if (executing) begin
          instr_d = INSTR_IN;
          addr_d  = {bank_sel, INSTR_IN[7:0]};
        end
      end
      exec_pkg::PH_Q2: begin
        if (executing && is_file) begin
          opnd_d = REG_RDATA_IN;
        end
      end
      exec_pkg::PH_Q3: begin
        if (executing) begin
          result_d   = alu_res;
          p_carry_d  = alu_c;
          p_ncarry_d = alu_dc;
          p_neg_d    = alu_n;
          p_ovf_d    = alu_ov;
          p_zero_d   = alu_z;
          // low eight from the first word, upper twelve from the second
          target_d   = {NEXT_WORD_IN[exec_pkg::JUMP_HI_W-1:0], instr_q[exec_pkg::JUMP_LO_W-1:0], 1'b0};
        end
      end
      exec_pkg::PH_Q4: begin
        if (executing) begin
          if (is_file && !to_file) begin
            accum_d = result_q;
          end
          if (is_orlit || is_dadj) begin
            accum_d = result_q;
          end
          if (is_inc) begin
            carry_d  = p_carry_q;
            ncarry_d = p_ncarry_q;
            neg_d    = p_neg_q;
            ovf_d    = p_ovf_q;
            zero_d   = p_zero_q;
          end
          if (is_orlit) begin
            neg_d  = p_neg_q;
            zero_d = p_zero_q;
          end
          if (is_dadj) begin
            carry_d = p_carry_q;
          end
          if (is_skip_op && skip_taken) begin
            state_d     = exec_pkg::ST_SKIP_IDLE;
            idle_left_d = next_two_word ? exec_pkg::SKIP_IDLE_TWO : exec_pkg::SKIP_IDLE_ONE;
          end
          if (is_jump) begin
            state_d = exec_pkg::ST_JUMP_IDLE;
          end
        end else if (state_q == exec_pkg::ST_SKIP_IDLE) begin
          idle_left_d = idle_left_q - 2'h1;
          if (idle_left_q == exec_pkg::SKIP_IDLE_ONE) begin
            state_d = exec_pkg::ST_EXEC;
          end
        end else begin
          state_d = exec_pkg::ST_EXEC;
        end
      end
      default: begin
        phase_d = exec_pkg::PH_Q1;
      end
    endcase
  end

  // registers, synchronous active-low reset
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      phase_q     <= exec_pkg::PH_Q1;
      state_q     <= exec_pkg::ST_EXEC;
      idle_left_q <= 2'h0;
      instr_q     <= 16'h0000;
      addr_q      <= 12'h000;
      opnd_q      <= '0;
      result_q    <= '0;
      target_q    <= '0;
      accum_q     <= exec_pkg::ACCUM_RESET;
      carry_q     <= 1'b0;
      ncarry_q    <= 1'b0;
      neg_q       <= 1'b0;
      ovf_q       <= 1'b0;
      zero_q      <= 1'b0;
      p_carry_q   <= 1'b0;
      p_ncarry_q  <= 1'b0;
      p_neg_q     <= 1'b0;
      p_ovf_q     <= 1'b0;
      p_zero_q    <= 1'b0;
    end else begin
      phase_q     <= phase_d;
      state_q     <= state_d;
      idle_left_q <= idle_left_d;
      instr_q     <= instr_d;
      addr_q      <= addr_d;
      opnd_q      <= opnd_d;
      result_q    <= result_d;
      target_q    <= target_d;
      accum_q     <= accum_d;
      carry_q     <= carry_d;
      ncarry_q    <= ncarry_d;
      neg_q       <= neg_d;
      ovf_q       <= ovf_d;
      zero_q      <= zero_d;
      p_carry_q   <= p_carry_d;
      p_ncarry_q  <= p_ncarry_d;
      p_neg_q     <= p_neg_d;
      p_ovf_q     <= p_ovf_d;
      p_zero_q    <= p_zero_d;
    end
  end

  // strobes toward register file, counter and fetch
  always_comb begin
    REG_RD_EN_OUT = executing && is_file && (phase_q == exec_pkg::PH_Q2);
    REG_WR_EN_OUT = executing && is_file && to_file && (phase_q == exec_pkg::PH_Q4);
    PC_LOAD_OUT   = executing && is_jump && (phase_q == exec_pkg::PH_Q4);
    WORD_DONE_OUT = (phase_q == exec_pkg::PH_Q4);
    DISCARD_OUT   = !executing && (phase_q == exec_pkg::PH_Q4);
    UNHANDLED_OUT = executing && (phase_q != exec_pkg::PH_Q1) && (alu_op == exec_pkg::ALU_NONE) && !is_jump;
  end

  // data outputs straight from flip-flops
  assign REG_ADDR_OUT          = addr_q;
  assign REG_WDATA_OUT         = result_q;
  assign PC_TARGET_OUT         = target_q;
  assign PHASE_OUT             = phase_q;
  assign ACCUM_OUT             = accum_q;
  assign CARRY_FLAG_OUT        = carry_q;
  assign NIBBLE_CARRY_FLAG_OUT = ncarry_q;
  assign NEG_FLAG_OUT          = neg_q;
  assign OVF_FLAG_OUT          = ovf_q;
  assign ZERO_FLAG_OUT         = zero_q;

endmodule : skip_branch_or_instr_exec

// ===== bench/skip_branch_or_instr_exec_asserts.sv
// Purpose: concurrent checks on the ports of the execution slice
// Assumes: one clock, synchronous active-low reset, phases advance every clock
// Notes:   bound to every instance of the execution slice
`timescale 1ns/10ps
module skip_branch_or_instr_exec_asserts #(
  parameter int DATA_W = exec_pkg::DATA_W
) (
  input wire logic              MCLK_IN,
  input wire logic              RESETN_IN,
  input wire logic [11:0]       REG_ADDR_OUT,
  input wire logic              REG_RD_EN_OUT,
  input wire logic              REG_WR_EN_OUT,
  input wire logic [20:0]       PC_TARGET_OUT,
  input wire logic              PC_LOAD_OUT,
  input wire logic              WORD_DONE_OUT,
  input wire logic              DISCARD_OUT,
  input wire logic              UNHANDLED_OUT,
  input wire logic [1:0]        PHASE_OUT,
  input wire logic [DATA_W-1:0] ACCUM_OUT,
  input wire logic              CARRY_FLAG_OUT,
  input wire logic              NIBBLE_CARRY_FLAG_OUT,
  input wire logic              NEG_FLAG_OUT,
  input wire logic              OVF_FLAG_OUT,
  input wire logic              ZERO_FLAG_OUT
);
  // all checks share the one clock and its reset
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  // phase sequencing and strobe placement
  phase_step_a: assert property (1'h1 |=> PHASE_OUT == $past(PHASE_OUT) + 2'h1)
    else $error("phase did not advance by one");
  read_phase_a: assert property (REG_RD_EN_OUT |-> PHASE_OUT == exec_pkg::PH_Q2 && !UNHANDLED_OUT)
    else $error("register read outside the read phase");
  write_after_read_a: assert property (REG_WR_EN_OUT |-> PHASE_OUT == exec_pkg::PH_Q4 &&
    $past(REG_RD_EN_OUT, 2) && REG_ADDR_OUT == $past(REG_ADDR_OUT, 2))
    else $error("write without its read or with a moved address");
  word_done_a: assert property (1'h1 |-> WORD_DONE_OUT == (PHASE_OUT == exec_pkg::PH_Q4))
    else $error("word done not exactly in the last phase");
  // idle cycles and jumps
  discard_idle_a: assert property (DISCARD_OUT |-> PHASE_OUT == exec_pkg::PH_Q4 &&
    !REG_WR_EN_OUT && !PC_LOAD_OUT)
    else $error("discard outside an idle last phase");
  idle_limit_a: assert property (DISCARD_OUT ##4 DISCARD_OUT |=> ##3 !DISCARD_OUT)
    else $error("more than two idle cycles after a skip");
  jump_idle_a: assert property (PC_LOAD_OUT |-> PHASE_OUT == exec_pkg::PH_Q4 && !PC_TARGET_OUT[0]
    ##1 (!REG_RD_EN_OUT && !PC_LOAD_OUT)[*3] ##1 DISCARD_OUT ##4 !DISCARD_OUT)
    else $error("far jump not followed by exactly one idle cycle");
  // a reset in mid-instruction legally clears the state, so that edge is left out
  state_commit_a: assert property ($past(RESETN_IN) && !$stable({ACCUM_OUT, CARRY_FLAG_OUT,
    NIBBLE_CARRY_FLAG_OUT, NEG_FLAG_OUT, OVF_FLAG_OUT, ZERO_FLAG_OUT})
    |-> $past(PHASE_OUT) == exec_pkg::PH_Q4 && !$past(DISCARD_OUT))
    else $error("accumulator or flags changed outside a working last phase");
  foreign_quiet_a: assert property (UNHANDLED_OUT |-> !REG_RD_EN_OUT && !REG_WR_EN_OUT && !PC_LOAD_OUT)
    else $error("foreign opcode touched registers or counter");

  // main scenarios reached
  cover property (DISCARD_OUT ##4 DISCARD_OUT);
  cover property (PC_LOAD_OUT);
  cover property (REG_WR_EN_OUT);
  cover property (UNHANDLED_OUT);
endmodule : skip_branch_or_instr_exec_asserts

bind skip_branch_or_instr_exec skip_branch_or_instr_exec_asserts #(.DATA_W(DATA_W)) i_asserts (
  .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .REG_ADDR_OUT(REG_ADDR_OUT), .REG_RD_EN_OUT(REG_RD_EN_OUT),
  .REG_WR_EN_OUT(REG_WR_EN_OUT), .PC_TARGET_OUT(PC_TARGET_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
  .WORD_DONE_OUT(WORD_DONE_OUT), .DISCARD_OUT(DISCARD_OUT), .UNHANDLED_OUT(UNHANDLED_OUT),
  .PHASE_OUT(PHASE_OUT), .ACCUM_OUT(ACCUM_OUT), .CARRY_FLAG_OUT(CARRY_FLAG_OUT),
  .NIBBLE_CARRY_FLAG_OUT(NIBBLE_CARRY_FLAG_OUT), .NEG_FLAG_OUT(NEG_FLAG_OUT), .OVF_FLAG_OUT(OVF_FLAG_OUT),
  .ZERO_FLAG_OUT(ZERO_FLAG_OUT)
);

// ===== bench/skip_branch_or_instr_exec_tb.sv
// Purpose: self-checking bench for the execution slice
// Assumes: inputs change 1 ns after the rising edge, one instruction per four clocks
// Notes:   table rows run first, then the foreign-opcode case, then the reset case
`timescale 1ns/10ps
module skip_branch_or_instr_exec_tb;
  typedef struct packed {
    logic [15:0] ins;
    logic [15:0] nxt;
    logic [3:0]  bnk;
    logic [7:0]  rd;
    logic [11:0] adr;
    logic        rde;
    logic        wre;
    logic [7:0]  wd;
    logic        pcl;
    logic [20:0] pt;
    logic [1:0]  idl;
    logic [7:0]  acc;
    logic [4:0]  flg;
  } row_t;

  logic        MCLK_IN;
  logic        RESETN_IN;
  logic [15:0] INSTR_IN;
  logic [15:0] NEXT_WORD_IN;
  logic [3:0]  BANK_PTR_IN;
  logic [7:0]  REG_RDATA_IN;
  logic [11:0] REG_ADDR_OUT;
  logic        REG_RD_EN_OUT;
  logic        REG_WR_EN_OUT;
  logic [7:0]  REG_WDATA_OUT;
  logic [20:0] PC_TARGET_OUT;
  logic        PC_LOAD_OUT;
  logic        WORD_DONE_OUT;
  logic        DISCARD_OUT;
  logic        UNHANDLED_OUT;
  logic [1:0]  PHASE_OUT;
  logic [7:0]  ACCUM_OUT;
  logic [4:0]  flags;
  int          n_fail;
  int          num_checks;
  row_t        rows[20];

  skip_branch_or_instr_exec i_dut (
    .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .INSTR_IN(INSTR_IN), .NEXT_WORD_IN(NEXT_WORD_IN),
    .BANK_PTR_IN(BANK_PTR_IN), .REG_RDATA_IN(REG_RDATA_IN), .REG_ADDR_OUT(REG_ADDR_OUT),
    .REG_RD_EN_OUT(REG_RD_EN_OUT), .REG_WR_EN_OUT(REG_WR_EN_OUT), .REG_WDATA_OUT(REG_WDATA_OUT),
    .PC_TARGET_OUT(PC_TARGET_OUT), .PC_LOAD_OUT(PC_LOAD_OUT), .WORD_DONE_OUT(WORD_DONE_OUT),
    .DISCARD_OUT(DISCARD_OUT),
    .UNHANDLED_OUT(UNHANDLED_OUT), .PHASE_OUT(PHASE_OUT), .ACCUM_OUT(ACCUM_OUT),
    .CARRY_FLAG_OUT(flags[4]), .NIBBLE_CARRY_FLAG_OUT(flags[3]), .NEG_FLAG_OUT(flags[2]),
    .OVF_FLAG_OUT(flags[1]), .ZERO_FLAG_OUT(flags[0])
  );

  // free-running clock
  initial begin
    MCLK_IN = 1'h0;
    forever #25 MCLK_IN = ~MCLK_IN;
  end

  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic step();
    @(posedge MCLK_IN);
    #1;
  endtask : step

  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t strobe or flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_val(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  // idle cycle with a file op offered that must be ignored
  task automatic idle();
    INSTR_IN = 16'h2B00;
    NEXT_WORD_IN = 16'h2B00;
    for (int p = 0; p < 4; p++) begin
      cmp_bit(REG_RD_EN_OUT | REG_WR_EN_OUT | PC_LOAD_OUT, 1'h0);
      cmp_bit(DISCARD_OUT, p == 3);
      cmp_bit(WORD_DONE_OUT, p == 3);
      step();
    end
  endtask : idle

  task automatic exec(input row_t r);
    INSTR_IN = r.ins;
    NEXT_WORD_IN = r.nxt;
    BANK_PTR_IN = r.bnk;
    REG_RDATA_IN = r.rd;
    step();
    cmp_bit(REG_RD_EN_OUT, r.rde);
    cmp_bit(UNHANDLED_OUT, 1'h0);
    if (r.rde) cmp_val(21'(REG_ADDR_OUT), 21'(r.adr));
    step();
    step();
    cmp_bit(REG_WR_EN_OUT, r.wre);
    if (r.wre) cmp_val(21'(REG_WDATA_OUT), 21'(r.wd));
    cmp_bit(PC_LOAD_OUT, r.pcl);
    if (r.pcl) cmp_val(PC_TARGET_OUT, r.pt);
    step();
    repeat (r.idl) idle();
    cmp_val(21'(ACCUM_OUT), 21'(r.acc));
    cmp_val(21'(flags), 21'(r.flg));
  endtask : exec

  task automatic chk_reset();
    cmp_val(21'({PHASE_OUT, ACCUM_OUT, flags}), 21'h0);
    cmp_bit(REG_RD_EN_OUT | REG_WR_EN_OUT | PC_LOAD_OUT | DISCARD_OUT, 1'h0);
  endtask : chk_reset

  // watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end

  // main sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    RESETN_IN = 1'h0;
    INSTR_IN = 16'h0000;
    NEXT_WORD_IN = 16'h0000;
    BANK_PTR_IN = 4'h0;
    REG_RDATA_IN = 8'h00;
    rows[0] = '{16'h2F23, 16'h0000, 4'h5, 8'h01, 12'h523, 1'h1, 1'h1, 8'h00, 1'h0, 21'h0, 2'h1, 8'h00, 5'h00};
    rows[1] = '{16'h2C90, 16'h0000, 4'h5, 8'h05, 12'hF90, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h04, 5'h00};
    rows[2] = '{16'h2C10, 16'hEC00, 4'h5, 8'h01, 12'h010, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h2, 8'h00, 5'h00};
    rows[3] = '{16'h4F10, 16'hEF12, 4'h2, 8'h05, 12'h210, 1'h1, 1'h1, 8'h04, 1'h0, 21'h0, 2'h2, 8'h00, 5'h00};
    rows[4] = '{16'h4E7F, 16'h0000, 4'h2, 8'h01, 12'h07F, 1'h1, 1'h1, 8'h00, 1'h0, 21'h0, 2'h0, 8'h00, 5'h00};
    rows[5] = '{16'h3F44, 16'hC123, 4'h3, 8'hFF, 12'h344, 1'h1, 1'h1, 8'h00, 1'h0, 21'h0, 2'h2, 8'h00, 5'h00};
    rows[6] = '{16'h3D45, 16'hEE01, 4'h3, 8'h10, 12'h345, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h11, 5'h00};
    rows[7] = '{16'h4B01, 16'h0000, 4'h1, 8'h7F, 12'h101, 1'h1, 1'h1, 8'h80, 1'h0, 21'h0, 2'h1, 8'h11, 5'h00};
    rows[8] = '{16'h4902, 16'h0000, 4'h1, 8'hFF, 12'h102, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h00, 5'h00};
    rows[9] = '{16'h3F46, 16'hEE00, 4'h3, 8'hFF, 12'h346, 1'h1, 1'h1, 8'h00, 1'h0, 21'h0, 2'h2, 8'h00, 5'h00};
    rows[10] = '{16'h2905, 16'h0000, 4'h0, 8'h0F, 12'h005, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h10, 5'h08};
    rows[11] = '{16'h2B7F, 16'h0000, 4'h9, 8'h7F, 12'h97F, 1'h1, 1'h1, 8'h80, 1'h0, 21'h0, 2'h0, 8'h10, 5'h0E};
    rows[12] = '{16'h2906, 16'h0000, 4'h0, 8'hFF, 12'h006, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h00, 5'h19};
    rows[13] = '{16'h0980, 16'h0000, 4'h0, 8'h00, 12'h000, 1'h0, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h80, 5'h1C};
    rows[14] = '{16'h0007, 16'h0000, 4'h0, 8'h00, 12'h000, 1'h0, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'hE6, 5'h1C};
    rows[15] = '{16'h0007, 16'h0000, 4'h0, 8'h00, 12'h000, 1'h0, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h4C, 5'h1C};
    rows[16] = '{16'hEF5A, 16'hF123, 4'h0, 8'h00, 12'h000, 1'h0, 1'h0, 8'h00, 1'h1, 21'h246B4, 2'h1, 8'h4C, 5'h1C};
    rows[17] = '{16'hEFFF, 16'hFFFF, 4'h0, 8'h00, 12'h000, 1'h0, 1'h0, 8'h00, 1'h1, 21'h1FFFFE, 2'h1, 8'h4C, 5'h1C};
    rows[18] = '{16'h0900, 16'h0000, 4'h0, 8'h00, 12'h000, 1'h0, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h4C, 5'h18};
    rows[19] = '{16'h2920, 16'h0000, 4'h0, 8'h41, 12'h020, 1'h1, 1'h0, 8'h00, 1'h0, 21'h0, 2'h0, 8'h42, 5'h00};
    repeat (8) step();
    chk_reset();
    RESETN_IN = 1'h1;
    for (int i = 0; i < 19; i++) begin
      exec(rows[i]);
    end
    // opcode outside this slice must stay quiet
    INSTR_IN = 16'h6E00;
    step();
    cmp_bit(UNHANDLED_OUT, 1'h1);
    cmp_bit(REG_RD_EN_OUT, 1'h0);
    step();
    step();
    cmp_bit(REG_WR_EN_OUT | PC_LOAD_OUT, 1'h0);
    step();
    cmp_val(21'(ACCUM_OUT), 21'h4C);
    // reset in mid-instruction, then restart at the decode phase
    INSTR_IN = 16'h2B00;
    step();
    step();
    RESETN_IN = 1'h0;
    step();
    chk_reset();
    RESETN_IN = 1'h1;
    exec(rows[19]);
    give_verdict();
  end
endmodule : skip_branch_or_instr_exec_tb
